/* File: verilog/tag_guard_pkg.sv */
// Constants, field layouts and types of the tag parity guard.
// Assumes a single clock domain shared with the system bus.
package tag_guard_pkg;

    ////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int IDX_W = 8;
    localparam int TAG_W = 17;
    localparam int OFF_W = 5;
    localparam int CTL_W = 3;
    localparam int ADDR_W = TAG_W + IDX_W + OFF_W;

    // Tag control fields
    localparam int CTL_VALID = 0;
    localparam int CTL_DIRTY = 1;
    localparam int CTL_SHARED = 2;

    ////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam int WB_AW = 8;
    localparam logic [WB_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [WB_AW-1:0] REG_UE_LOG = 8'h04;
    localparam logic [WB_AW-1:0] REG_UE_ADDR = 8'h08;
    localparam logic [WB_AW-1:0] REG_IRQ_STAT = 8'h0C;
    localparam logic [WB_AW-1:0] REG_IRQ_MASK = 8'h10;

    // Control register
    localparam int CTRL_ALLOC_BIT = 0;
    localparam logic CTRL_ALLOC_RST = 1'b1;

    // Uncorrectable error log
    localparam int UE_W = 4;
    localparam int UE_PAR_BIT = 0;
    localparam int UE_TCPAR_BIT = 1;
    localparam int UE_MISS_BIT = 2;
    localparam int UE_CPU_BIT = 3;
    localparam logic [UE_W-1:0] UE_RST = 4'h0;

    // Interrupt status and mask
    localparam int IRQ_W = 2;
    localparam int IRQ_LOG_BIT = 0;
    localparam int IRQ_MISS_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////
    // Commands and states
    typedef enum logic [1:0] {
        CPU_RD_BLOCK = 2'h0,
        CPU_WR_BLOCK = 2'h1,
        CPU_LD_LOCK  = 2'h2,
        CPU_ST_COND  = 2'h3
    } cpu_cmd_type;

    typedef enum logic [1:0] {
        SB_READ  = 2'h0,
        SB_WRITE = 2'h1,
        SB_EXCH  = 2'h2,
        SB_OTHER = 2'h3
    } sb_cmd_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_CHECK = 2'b11,
        ST_DONE  = 2'b10
    } state_type;

endpackage

/* File: verilog/tag_port_if.sv */
// Tag and tag control store access port.
// Assumes one clock shared by controller and store.
`timescale 1ns/10ps
interface tag_port_if #(
    parameter int IDX_W = 8,
    parameter int TAG_W = 17,
    parameter int CTL_W = 3
);
    logic             rd_en;
    logic             wr_en;
    logic [IDX_W-1:0] idx;
    logic [TAG_W-1:0] wr_tag;
    logic [CTL_W-1:0] wr_ctl;
    logic [TAG_W-1:0] rd_tag;
    logic             rd_tag_par;
    logic [CTL_W-1:0] rd_ctl;
    logic             rd_ctl_par;

    modport ctrl (output rd_en, wr_en, idx, wr_tag, wr_ctl,
                  input rd_tag, rd_tag_par, rd_ctl, rd_ctl_par);
    modport mem (input rd_en, wr_en, idx, wr_tag, wr_ctl,
                 output rd_tag, rd_tag_par, rd_ctl, rd_ctl_par);
endinterface

/* File: verilog/tag_store.sv */
// Tag and tag control memory with stored parity and registered read.
// Assumes reads and writes never target the same cycle.
`timescale 1ns/10ps
module tag_store #(
    parameter int IDX_W = 8,
    parameter int TAG_W = 17,
    parameter int CTL_W = 3
) (
    // Clock
    input wire logic clk_i,
    // Access port
    tag_port_if.mem  port
);
    localparam int DEPTH = 1 << IDX_W;

    logic [TAG_W:0] tag_mem [DEPTH];
    logic [CTL_W:0] ctl_mem [DEPTH];
    logic [TAG_W:0] tag_rd_q;
    logic [CTL_W:0] ctl_rd_q;

    initial begin
        if (IDX_W < 1 || TAG_W < 1 || CTL_W < 1) begin
            $error("tag_store: widths must be positive");
        end
    end

    // Even parity stored with every entry
    always_ff @(posedge clk_i) begin
        if (port.wr_en) begin
            tag_mem[port.idx] <= {^port.wr_tag, port.wr_tag};
            ctl_mem[port.idx] <= {^port.wr_ctl, port.wr_ctl};
        end
        if (port.rd_en) begin
            tag_rd_q <= tag_mem[port.idx];
            ctl_rd_q <= ctl_mem[port.idx];
        end
    end

    assign port.rd_tag = tag_rd_q[TAG_W-1:0];
    assign port.rd_tag_par = tag_rd_q[TAG_W];
    assign port.rd_ctl = ctl_rd_q[CTL_W-1:0];
    assign port.rd_ctl_par = ctl_rd_q[CTL_W];

endmodule

/* File: verilog/parity_check.sv */
// Even parity checker for one stored field.
// Assumes enable is high only in the cycle the read data is valid.
`timescale 1ns/10ps
module parity_check #(
    parameter int W = 8
) (
    // Field
    input  wire logic [W-1:0] data_i,
    input  wire logic         par_i,
    input  wire logic         en_i,
    // Result
    output logic              err_o
);
    initial begin
        if (W < 1) begin
            $error("parity_check: W must be positive");
        end
    end

    assign err_o = en_i & ((^data_i) != par_i);

endmodule

/* File: verilog/tag_guard.sv */
// Backup cache tag probe controller with tag parity error handling.
// Assumes processor and system bus share clk_i; Wishbone classic slave.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps

// Operation
// - Tag parity is checked only in the cycle a probe read returns.
// - Bus probe parity error fails the probe, logs error and address.
// - Bus probe parity error sets the parity fault flag in the log.
// - Error line pulses at the next transaction-start or idle bus cycle.
// - Failed bus probe never accepts bus write data.
// - Failed bus probe never drives data, even on a dirty hit.
// - Failed bus probe leaves data, tag and control stores untouched.
// - Allocation stays off until log clears and enable is set again.
// - Processor cycle with parity error becomes a null bus cycle.
// - Such a cycle moves no bus data and keeps the cache unchanged.
// - Such a cycle gets a hard error acknowledge and error line pulse.
// - Processor cycle errors are logged with address, then frozen.
// - Errors while the log is set only mark a missed error.
// - Failed read or exchange probe drives uncorrectable line on data return.
// - The error line raises a hardware interrupt in every processor.
module tag_guard
    import tag_guard_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic [WB_AW-1:0]  adr_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    input  wire logic              we_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    output logic                   ack_o,
    output logic                   irq_o,
    // Processor requests
    input  wire logic              cpu_req_i,
    input  wire logic [1:0]        cpu_cmd_i,
    input  wire logic [ADDR_W-1:0] cpu_addr_i,
    output logic                   cpu_ack_o,
    output logic                   cpu_hard_err_o,
    output logic                   bus_start_o,
    output logic                   null_bus_cycle_o,
    // System bus probes
    input  wire logic              sb_probe_i,
    input  wire logic [1:0]        sb_cmd_i,
    input  wire logic [ADDR_W-1:0] sb_addr_i,
    output logic                   sb_probe_ready_o,
    output logic                   sb_done_o,
    output logic                   sb_fail_o,
    output logic                   sb_hit_o,
    output logic                   sb_accept_wdata_o,
    output logic                   sb_drive_data_o,
    // System bus cycle status and error lines
    input  wire logic              sb_t0_i,
    input  wire logic              sb_idle_i,
    input  wire logic              sb_rdata_ret_i,
    output logic                   bus_err_line_o,
    output logic                   bus_uncorr_error_line_o,
    output logic                   cache_alloc_enable_o
);

    ////////////////////////////////////////////////////////////////////
    // Tag store and parity checkers
    tag_port_if #(.IDX_W(IDX_W), .TAG_W(TAG_W), .CTL_W(CTL_W)) tp ();

    tag_store #(.IDX_W(IDX_W), .TAG_W(TAG_W), .CTL_W(CTL_W)) u_store (
        .clk_i (clk_i),
        .port  (tp.mem)
    );

    state_type         state_q, state_d;
    logic              chk_en;
    logic              tag_par_err;
    logic              ctl_par_err;

    assign chk_en = (state_q == ST_CHECK);

    parity_check #(.W(TAG_W)) u_tag_chk (
        .data_i (tp.rd_tag),
        .par_i  (tp.rd_tag_par),
        .en_i   (chk_en),
        .err_o  (tag_par_err)
    );

    parity_check #(.W(CTL_W)) u_ctl_chk (
        .data_i (tp.rd_ctl),
        .par_i  (tp.rd_ctl_par),
        .en_i   (chk_en),
        .err_o  (ctl_par_err)
    );

    ////////////////////////////////////////////////////////////////////
    // Probe sequencer state
    logic              src_cpu_q, src_cpu_d;
    logic [1:0]        cmd_q, cmd_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic              cpu_ack_q, cpu_ack_d;
    logic              hard_err_q, hard_err_d;
    logic              bus_start_q, bus_start_d;
    logic              null_q, null_d;
    logic              sb_done_q, sb_done_d;
    logic              sb_fail_q, sb_fail_d;
    logic              sb_hit_q, sb_hit_d;
    logic              sb_acc_q, sb_acc_d;
    logic              sb_drv_q, sb_drv_d;

    // Error and register state
    logic [UE_W-1:0]   ue_q, ue_d;
    logic [ADDR_W-1:0] ue_addr_q, ue_addr_d;
    logic              alloc_en_q, alloc_en_d;
    logic              err_pend_q, err_pend_d;
    logic              err_line_q, err_line_d;
    logic              ue_pend_q, ue_pend_d;
    logic              ue_line_q, ue_line_d;
    logic [IRQ_W-1:0]  irq_stat_q, irq_stat_d;
    logic [IRQ_W-1:0]  irq_mask_q, irq_mask_d;
    logic              irq_q, irq_d;
    logic              ack_q, ack_d;
    logic [31:0]       rdat_q, rdat_d;

    // Probe decode
    logic              any_err;
    logic              ue_busy;
    logic              hit;
    logic              log_evt;
    logic              miss_evt;
    logic              wb_wr;
    logic [31:0]       rd_mux;

    assign any_err = tag_par_err | ctl_par_err;
    assign ue_busy = ue_q[UE_PAR_BIT] | ue_q[UE_TCPAR_BIT];
    assign hit = tp.rd_ctl[CTL_VALID] & (tp.rd_tag == addr_q[ADDR_W-1 -: TAG_W]);
    assign log_evt = any_err & ~ue_busy;
    assign miss_evt = any_err & ue_busy;
    assign wb_wr = cyc_i & stb_i & we_i & ack_q & sel_i[0];

    ////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_d = state_q;
        src_cpu_d = src_cpu_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        cpu_ack_d = 1'b0;
        hard_err_d = 1'b0;
        bus_start_d = 1'b0;
        null_d = 1'b0;
        sb_done_d = 1'b0;
        sb_fail_d = 1'b0;
        sb_hit_d = 1'b0;
        sb_acc_d = 1'b0;
        sb_drv_d = 1'b0;
        tp.rd_en = 1'b0;
        tp.wr_en = 1'b0;
        tp.idx = addr_q[OFF_W +: IDX_W];
        tp.wr_tag = addr_q[ADDR_W-1 -: TAG_W];
        tp.wr_ctl = '0;
        case (state_q)
            ST_IDLE: begin
                // Bus probes take priority over processor requests
                if (sb_probe_i) begin
                    src_cpu_d = 1'b0;
                    cmd_d = sb_cmd_i;
                    addr_d = sb_addr_i;
                    state_d = ST_READ;
                end else if (cpu_req_i) begin
                    src_cpu_d = 1'b1;
                    cmd_d = cpu_cmd_i;
                    addr_d = cpu_addr_i;
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                tp.rd_en = 1'b1;
                state_d = ST_CHECK;
            end
            ST_CHECK: begin
                state_d = ST_DONE;
                if (src_cpu_q) begin
                    cpu_ack_d = 1'b1;
                    if (any_err) begin
                        hard_err_d = 1'b1;
                        null_d = 1'b1;
                    end else begin
                        bus_start_d = 1'b1;
                        // Allocate on miss only while enabled
                        if (!hit && alloc_en_q) begin
                            tp.wr_en = 1'b1;
                            tp.wr_ctl[CTL_VALID] = 1'b1;
                            tp.wr_ctl[CTL_DIRTY] = (cmd_q == CPU_WR_BLOCK) || (cmd_q == CPU_ST_COND);
                        end
                    end
                end else begin
                    sb_done_d = 1'b1;
                    if (any_err) begin
                        sb_fail_d = 1'b1;
                    end else begin
                        sb_hit_d = hit;
                        sb_acc_d = hit && (cmd_q == SB_WRITE);
                        sb_drv_d = hit && tp.rd_ctl[CTL_DIRTY]
                                   && ((cmd_q == SB_READ) || (cmd_q == SB_EXCH));
                    end
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Error log, error lines, registers
    always_comb begin
        ue_d = ue_q;
        ue_addr_d = ue_addr_q;
        alloc_en_d = alloc_en_q;
        err_pend_d = err_pend_q;
        err_line_d = 1'b0;
        ue_pend_d = ue_pend_q;
        ue_line_d = 1'b0;
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        ack_d = cyc_i & stb_i & ~ack_q;
        rdat_d = rdat_q;
        rd_mux = 32'h0000_0000;

        // Software writes first, hardware sets override
        if (wb_wr) begin
            case (adr_i)
                REG_UE_LOG: ue_d = ue_q & ~dat_i[UE_W-1:0];
                REG_IRQ_STAT: irq_stat_d = irq_stat_q & ~dat_i[IRQ_W-1:0];
                REG_IRQ_MASK: irq_mask_d = dat_i[IRQ_W-1:0];
                default: begin
                end
            endcase
            // Enable takes only with both parity fault bits of the log clear
            if (adr_i == REG_CTRL) begin
                alloc_en_d = dat_i[CTRL_ALLOC_BIT] & ~(ue_q[UE_PAR_BIT] | ue_q[UE_TCPAR_BIT]);
            end
        end

        if (log_evt) begin
            ue_d[UE_PAR_BIT] = 1'b1;
            ue_d[UE_TCPAR_BIT] = ctl_par_err;
            ue_d[UE_CPU_BIT] = src_cpu_q;
            ue_addr_d = addr_q;
            irq_stat_d[IRQ_LOG_BIT] = 1'b1;
        end
        if (miss_evt) begin
            ue_d[UE_MISS_BIT] = 1'b1;
            irq_stat_d[IRQ_MISS_BIT] = 1'b1;
        end
        if (any_err) begin
            alloc_en_d = 1'b0;
            err_pend_d = 1'b1;
            if (!src_cpu_q && ((cmd_q == SB_READ) || (cmd_q == SB_EXCH))) begin
                ue_pend_d = 1'b1;
            end
        end

        // Error line on next start or idle cycle
        if (err_pend_q && (sb_t0_i || sb_idle_i) && !any_err) begin
            err_line_d = 1'b1;
            err_pend_d = 1'b0;
        end
        // Uncorrectable line as read data returns
        if (ue_pend_q && sb_rdata_ret_i && !any_err) begin
            ue_line_d = 1'b1;
            ue_pend_d = 1'b0;
        end

        case (adr_i)
            REG_CTRL: rd_mux[CTRL_ALLOC_BIT] = alloc_en_q;
            REG_UE_LOG: rd_mux[UE_W-1:0] = ue_q;
            REG_UE_ADDR: rd_mux[ADDR_W-1:0] = ue_addr_q;
            REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
            REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
            default: rd_mux = 32'h0000_0000;
        endcase
        if (cyc_i && stb_i && !ack_q) begin
            rdat_d = rd_mux;
        end
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            src_cpu_q <= 1'b0;
            cmd_q <= 2'h0;
            addr_q <= '0;
            cpu_ack_q <= 1'b0;
            hard_err_q <= 1'b0;
            bus_start_q <= 1'b0;
            null_q <= 1'b0;
            sb_done_q <= 1'b0;
            sb_fail_q <= 1'b0;
            sb_hit_q <= 1'b0;
            sb_acc_q <= 1'b0;
            sb_drv_q <= 1'b0;
            ue_q <= UE_RST;
            ue_addr_q <= '0;
            alloc_en_q <= CTRL_ALLOC_RST;
            err_pend_q <= 1'b0;
            err_line_q <= 1'b0;
            ue_pend_q <= 1'b0;
            ue_line_q <= 1'b0;
            irq_stat_q <= IRQ_RST;
            irq_mask_q <= IRQ_RST;
            irq_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            src_cpu_q <= src_cpu_d;
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            cpu_ack_q <= cpu_ack_d;
            hard_err_q <= hard_err_d;
            bus_start_q <= bus_start_d;
            null_q <= null_d;
            sb_done_q <= sb_done_d;
            sb_fail_q <= sb_fail_d;
            sb_hit_q <= sb_hit_d;
            sb_acc_q <= sb_acc_d;
            sb_drv_q <= sb_drv_d;
            ue_q <= ue_d;
            ue_addr_q <= ue_addr_d;
            alloc_en_q <= alloc_en_d;
            err_pend_q <= err_pend_d;
            err_line_q <= err_line_d;
            ue_pend_q <= ue_pend_d;
            ue_line_q <= ue_line_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= irq_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign dat_o = rdat_q;
    assign ack_o = ack_q;
    assign irq_o = irq_q;
    assign cpu_ack_o = cpu_ack_q;
    assign cpu_hard_err_o = hard_err_q;
    assign bus_start_o = bus_start_q;
    assign null_bus_cycle_o = null_q;
    assign sb_probe_ready_o = (state_q == ST_IDLE);
    assign sb_done_o = sb_done_q;
    assign sb_fail_o = sb_fail_q;
    assign sb_hit_o = sb_hit_q;
    assign sb_accept_wdata_o = sb_acc_q;
    assign sb_drive_data_o = sb_drv_q;
    assign bus_err_line_o = err_line_q;
    assign bus_uncorr_error_line_o = ue_line_q;
    assign cache_alloc_enable_o = alloc_en_q;

endmodule

/* File: sim/tag_guard_monitor.sv */
// Port checker for the tag parity guard.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module tag_guard_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic ack_o,
    input wire logic cpu_req_i,
    input wire logic sb_probe_i,
    input wire logic sb_probe_ready_o,
    input wire logic cpu_ack_o,
    input wire logic cpu_hard_err_o,
    input wire logic bus_start_o,
    input wire logic null_bus_cycle_o,
    input wire logic sb_done_o,
    input wire logic sb_fail_o,
    input wire logic sb_hit_o,
    input wire logic sb_accept_wdata_o,
    input wire logic sb_drive_data_o,
    input wire logic sb_t0_i,
    input wire logic sb_idle_i,
    input wire logic sb_rdata_ret_i,
    input wire logic bus_err_line_o,
    input wire logic bus_uncorr_error_line_o,
    input wire logic cache_alloc_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_cpu_answer: assert property (cpu_req_i && sb_probe_ready_o && !sb_probe_i |-> ##3 cpu_ack_o)
        else $error("processor answer missing");
    a_probe_answer: assert property (sb_probe_i && sb_probe_ready_o |-> ##3 sb_done_o)
        else $error("probe answer missing");
    a_null_on_fault: assert property (cpu_hard_err_o |-> cpu_ack_o && null_bus_cycle_o && !bus_start_o)
        else $error("faulty cycle not nulled");
    a_start_or_err: assert property (cpu_ack_o |-> bus_start_o ^ cpu_hard_err_o)
        else $error("answer kind wrong");
    a_fail_quiet: assert property (sb_fail_o |-> sb_done_o && !sb_hit_o && !sb_accept_wdata_o)
        else $error("failed probe moved data");
    a_drive_hit: assert property (sb_drive_data_o |-> sb_done_o && sb_hit_o && !sb_fail_o)
        else $error("data driven without clean hit");
    a_err_slot: assert property (bus_err_line_o |-> ($past(sb_t0_i) || $past(sb_idle_i)) ##1 !bus_err_line_o)
        else $error("error line outside start or idle slot");
    a_err_after: assert property ((cpu_hard_err_o || sb_fail_o) && (sb_t0_i || sb_idle_i) |=> bus_err_line_o)
        else $error("error line not raised");
    a_uncorr_slot: assert property (bus_uncorr_error_line_o |-> $past(sb_rdata_ret_i))
        else $error("uncorrectable line off data return");
    a_alloc_off: assert property (cpu_hard_err_o || sb_fail_o |-> !cache_alloc_enable_o)
        else $error("allocation still enabled");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
endmodule

bind tag_guard tag_guard_monitor u_mon (
    .clk_i, .rst_i, .ack_o, .cpu_req_i, .sb_probe_i, .sb_probe_ready_o, .cpu_ack_o, .cpu_hard_err_o,
    .bus_start_o, .null_bus_cycle_o, .sb_done_o, .sb_fail_o, .sb_hit_o, .sb_accept_wdata_o,
    .sb_drive_data_o, .sb_t0_i, .sb_idle_i, .sb_rdata_ret_i, .bus_err_line_o, .bus_uncorr_error_line_o,
    .cache_alloc_enable_o
);

/* File: sim/cmd_partner.sv */
// Processor and system bus commander model.
// Assumes each request is held until the guard answers it.
`timescale 1ns/10ps
module cmd_partner
    import tag_guard_pkg::*;
(
    // Clock and answers
    input  wire logic              clk_i,
    input  wire logic              cpu_ack_i,
    input  wire logic              sb_done_i,
    // Requests
    output logic                   cpu_req_o,
    output logic      [1:0]        cpu_cmd_o,
    output logic      [ADDR_W-1:0] cpu_addr_o,
    output logic                   sb_probe_o,
    output logic      [1:0]        sb_cmd_o,
    output logic      [ADDR_W-1:0] sb_addr_o
);
    initial begin
        {cpu_req_o, cpu_cmd_o, cpu_addr_o, sb_probe_o, sb_cmd_o, sb_addr_o} = '0;
    end

    // One request after gap idle cycles; address inverted once released
    task automatic op(input logic s, input logic [1:0] c, input logic [ADDR_W-1:0] a, input int gap);
        int n;
        repeat (gap) @(posedge clk_i);
        if (s) begin
            sb_cmd_o   <= c;
            sb_addr_o  <= a;
            sb_probe_o <= 1'b1;
        end else begin
            cpu_cmd_o  <= c;
            cpu_addr_o <= a;
            cpu_req_o  <= 1'b1;
        end
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(s ? sb_done_i : cpu_ack_i) && n < 40);
        if (!(s ? sb_done_i : cpu_ack_i)) begin
            tag_guard_tb_top.num_errors++;
            tag_guard_tb_top.wrap_up();
        end
        {cpu_req_o, sb_probe_o} <= 2'b00;
        {cpu_addr_o, sb_addr_o} <= {~cpu_addr_o, ~sb_addr_o};
        @(posedge clk_i);
    endtask
endmodule

/* File: sim/tag_guard_tb_top.sv */
// Self-checking bench for the tag parity guard.
// Assumes cmd_partner issues processor and bus probe requests.
`timescale 1ns/10ps
module tag_guard_tb_top;
    import tag_guard_pkg::*;

    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic [WB_AW-1:0]  adr_i = '0;
    logic [31:0]       dat_i = '0, dat_o, obs, e;
    logic              we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o, irq_o;
    logic [3:0]        sel_i = 4'h0;
    logic              cpu_req_i, cpu_ack_o, cpu_hard_err_o, bus_start_o, null_bus_cycle_o;
    logic [1:0]        cpu_cmd_i, sb_cmd_i;
    logic [ADDR_W-1:0] cpu_addr_i, sb_addr_i, a;
    logic              sb_probe_i, sb_probe_ready_o, sb_done_o, sb_fail_o, sb_hit_o, cache_alloc_enable_o;
    logic              sb_accept_wdata_o, sb_drive_data_o, bus_err_line_o, bus_uncorr_error_line_o;
    logic              sb_t0_i = 1'b0, sb_idle_i = 1'b0, sb_rdata_ret_i = 1'b0;
    logic [31:0]       exp_q[$];
    int                seed = 2229;
    int                num_errors = 0;
    int                samples_checked = 0;
    logic              inj = 1'b0;

    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) {sb_t0_i, sb_idle_i, sb_rdata_ret_i} <= 3'($random(seed));

    tag_guard uut (
        .clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .irq_o,
        .cpu_req_i, .cpu_cmd_i, .cpu_addr_i, .cpu_ack_o, .cpu_hard_err_o, .bus_start_o, .null_bus_cycle_o,
        .sb_probe_i, .sb_cmd_i, .sb_addr_i, .sb_probe_ready_o, .sb_done_o, .sb_fail_o, .sb_hit_o,
        .sb_accept_wdata_o, .sb_drive_data_o, .sb_t0_i, .sb_idle_i, .sb_rdata_ret_i, .bus_err_line_o,
        .bus_uncorr_error_line_o, .cache_alloc_enable_o
    );
    cmd_partner pm (
        .clk_i, .cpu_ack_i(cpu_ack_o), .sb_done_i(sb_done_o), .cpu_req_o(cpu_req_i), .cpu_cmd_o(cpu_cmd_i),
        .cpu_addr_o(cpu_addr_i), .sb_probe_o(sb_probe_i), .sb_cmd_o(sb_cmd_i), .sb_addr_o(sb_addr_i)
    );

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic wb(input logic w, input logic [WB_AW-1:0] ad, input logic [31:0] d, input logic [31:0] x);
        int n;
        {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 4'hf, ad, d};
        if (!w) exp_q.push_back(x);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!ack_o && n < 40);
        if (!ack_o) begin
            num_errors++;
            wrap_up();
        end
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask

    task automatic wrap_up();
        if (exp_q.size() != 0) num_errors++;
        $display("checked %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Result watcher: oldest note against each answer
    always @(posedge clk_i) begin
        if ((ack_o && !we_i) || cpu_ack_o || sb_done_o) begin
            obs = ack_o ? dat_o : cpu_ack_o ? {29'h0000_0000, cpu_hard_err_o, null_bus_cycle_o, bus_start_o}
                | 32'h0000_0100 : {29'h0000_0000, sb_fail_o, sb_hit_o, sb_accept_wdata_o} | 32'h0000_0200;
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_beef;
            chk(obs, e);
        end
        if (bus_err_line_o || bus_uncorr_error_line_o) chk(32'h0000_0001, 32'(inj));
    end

    ////////////////////////////////////////////////////////////
    initial begin
        for (int k = 0; k < (1 << IDX_W); k++) {uut.u_store.tag_mem[k], uut.u_store.ctl_mem[k]} = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({sb_probe_ready_o, cache_alloc_enable_o, irq_o, ack_o}, 32'h0000_000c);
        for (int i = 0; i < 6; i++) wb(1'b0, 8'(i * 4), '0, (i == 0) ? 32'h0000_0001 : '0);
        wb(1'b1, REG_IRQ_MASK, 32'hffff_ffff, '0);
        wb(1'b1, REG_UE_ADDR, 32'hffff_ffff, '0);
        wb(1'b1, 8'h14, 32'hffff_ffff, '0);
        wb(1'b1, REG_UE_LOG, 32'hffff_ffff, '0);
        wb(1'b0, REG_IRQ_MASK, '0, 32'h0000_0003);
        wb(1'b0, REG_UE_ADDR, '0, '0);
        wb(1'b0, REG_UE_LOG, '0, '0);
        wb(1'b1, REG_CTRL, '0, '0);
        chk({irq_o, cache_alloc_enable_o}, '0);
        wb(1'b1, REG_CTRL, 32'h0000_0001, '0);
        chk(cache_alloc_enable_o, 32'h0000_0001);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            a = ADDR_W'($random(seed));
            a[OFF_W +: IDX_W] = IDX_W'(i * 37);
            for (int c = 0; c < 5; c++) begin
                exp_q.push_back(32'h0000_0101);
                pm.op(1'b0, 2'(c % 4), a, $unsigned($random(seed)) % 3);
            end
            for (int c = 0; c < 3; c++) begin
                exp_q.push_back(32'h0000_0202 | 32'(c == SB_WRITE));
                pm.op(1'b1, 2'(c), a, 0);
            end
            for (int c = 0; c < 4; c++) begin
                exp_q.push_back(32'h0000_0200);
                pm.op(1'b1, 2'(c), a ^ ADDR_W'(1 << (OFF_W + IDX_W)), $unsigned($random(seed)) % 3);
            end
        end
        // Corrupt one stored tag, then probe it from the bus
        inj = 1'b1;
        uut.u_store.tag_mem[a[OFF_W +: IDX_W]][0] ^= 1'b1;
        exp_q.push_back(32'h0000_0204);
        pm.op(1'b1, SB_READ, a, 0);
        $display("test probes done");
        wb(1'b0, REG_UE_LOG, '0, 32'h0000_0001);
        chk({irq_o, cache_alloc_enable_o}, 32'h0000_0002);
        repeat (4) @(posedge clk_i);
        wrap_up();
    end
endmodule
